// file: arx_aux_reply_irq_status.v
`timescale 1ns/1ns
`default_nettype none
`include "arx_regs.vh"

module arx_aux_reply_irq_status #(
    parameter HPD_LOSS_CYC = `ARX_HPD_LOSS_CYC
) (
    // Clock and reset
    input  wire         CORE_CLK_I,
    input  wire         RST_N_I,
    // Host register port
    input  wire [11:0]  REG_ADDR_I,
    input  wire         REG_WR_I,
    input  wire [31:0]  REG_WDATA_I,
    input  wire         REG_RD_I,
    output reg  [31:0]  REG_RDATA_O,
    output reg          REG_RVALID_O,
    // AUX request controller
    input  wire         AUX_REQ_START_I,
    input  wire [3:0]   AUX_REQ_LEN_I,
    input  wire         AUX_REQ_ACTIVE_I,
    // AUX reply detector
    input  wire         AUX_REPLY_ACTIVE_I,
    input  wire         AUX_REPLY_BYTE_VLD_I,
    input  wire [7:0]   AUX_REPLY_BYTE_I,
    input  wire         AUX_REPLY_DONE_I,
    input  wire [3:0]   AUX_REPLY_CODE_I,
    input  wire         AUX_REPLY_TIMEOUT_I,
    // Video and packet path
    input  wire         USER_FIFO_OVF_I,
    input  wire         EXTENDED_PACKET_SENT_I,
    // Hot-plug line
    input  wire         HOT_PLUG_I,
    // Interrupt
    output reg          IRQ_O
);
    // Address decode
    wire        sel_ovf;
    wire        sel_raw;
    wire        sel_fifo;
    wire        sel_code;
    wire        sel_cnt;
    wire        sel_stat;
    wire        sel_mask;
    wire        sel_dur;

    // Register state
    reg         overflow_q;
    reg  [3:0]  reply_code_q;
    reg  [7:0]  reply_cnt_q;
    reg  [5:0]  status_q;
    reg  [5:0]  status_d;
    reg  [5:0]  mask_q;
    reg         timeout_last_q;
    reg  [4:0]  target_q;
    reg  [4:0]  filled_q;
    reg         padding_q;
    reg  [31:0] rdata_d;

    // Reply FIFO hookup
    wire        fifo_push;
    wire [7:0]  fifo_push_data;
    wire        fifo_pop;
    wire [7:0]  fifo_head;
    wire        room_left;
    wire        pad_push;
    wire        byte_push;

    // Hot-plug monitor hookup
    wire        hot_plug_change;
    wire        hot_plug_pulse_seen;
    wire        hot_plug_irq_pulse;
    wire [15:0] hot_plug_duration;

    // Events feeding the status register
    wire        timeout_rise;
    wire [5:0]  status_set;
    wire        status_clear;
    wire [3:0]  raw_state;

    assign sel_ovf  = (REG_ADDR_I == `ARX_OFS_USER_OVF);
    assign sel_raw  = (REG_ADDR_I == `ARX_OFS_RAW_STATE);
    assign sel_fifo = (REG_ADDR_I == `ARX_OFS_REPLY_FIFO);
    assign sel_code = (REG_ADDR_I == `ARX_OFS_REPLY_CODE);
    assign sel_cnt  = (REG_ADDR_I == `ARX_OFS_REPLY_CNT);
    assign sel_stat = (REG_ADDR_I == `ARX_OFS_IRQ_STATUS);
    assign sel_mask = (REG_ADDR_I == `ARX_OFS_IRQ_MASK);
    assign sel_dur  = (REG_ADDR_I == `ARX_OFS_HPD_DUR);

    // Live levels, never latched
    assign raw_state[`ARX_RAW_TIMEOUT] = AUX_REPLY_TIMEOUT_I;
    assign raw_state[`ARX_RAW_REPLY]   = AUX_REPLY_ACTIVE_I;
    assign raw_state[`ARX_RAW_REQUEST] = AUX_REQ_ACTIVE_I;
    assign raw_state[`ARX_RAW_HPD]     = HOT_PLUG_I;

    arx_hpd_mon #(
        .LOSS_CYC (HPD_LOSS_CYC)
    ) u_hpd (
        .clk_i                 (CORE_CLK_I),
        .rst_n_i               (RST_N_I),
        .hot_plug_level_i      (HOT_PLUG_I),
        .hot_plug_change_o     (hot_plug_change),
        .hot_plug_pulse_seen_o (hot_plug_pulse_seen),
        .hot_plug_irq_pulse_o  (hot_plug_irq_pulse),
        .duration_o            (hot_plug_duration)
    );

    // Reply FIFO fill: bytes beyond the requested length are dropped, and
    // a short reply is padded with zeros so the host always finds exactly
    // the requested number of bytes.
    assign room_left      = (filled_q != target_q);
    assign byte_push      = AUX_REPLY_BYTE_VLD_I & room_left &
                            ~padding_q;
    assign pad_push       = padding_q & room_left;
    assign fifo_push      = (byte_push | pad_push) & ~AUX_REQ_START_I;
    assign fifo_push_data = pad_push ? 8'h00 : AUX_REPLY_BYTE_I;
    assign fifo_pop       = REG_RD_I & sel_fifo;

    arx_reply_fifo u_fifo (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RST_N_I),
        .flush_i     (AUX_REQ_START_I),
        .push_i      (fifo_push),
        .push_data_i (fifo_push_data),
        .pop_i       (fifo_pop),
        .head_o      (fifo_head),
        .count_o     ()
    );

    always @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            target_q  <= 5'h00;
            filled_q  <= 5'h00;
            padding_q <= 1'b0;
        end else if (AUX_REQ_START_I) begin
            // Length field holds count minus one
            target_q  <= {1'b0, AUX_REQ_LEN_I} + 5'h01;
            filled_q  <= 5'h00;
            padding_q <= 1'b0;
        end else begin
            if (fifo_push) begin
                filled_q <= filled_q + 5'h01;
            end
            if (AUX_REPLY_DONE_I) begin
                padding_q <= 1'b1;
            end else if (!room_left || (pad_push && filled_q == target_q -
                                                    5'h01)) begin
                padding_q <= 1'b0;
            end
        end
    end

    // Timeout is an event on its rising edge; the level shows in raw state
    assign timeout_rise = AUX_REPLY_TIMEOUT_I & ~timeout_last_q;

    assign status_set[`ARX_ST_EXT_PKT]    = EXTENDED_PACKET_SENT_I;
    assign status_set[`ARX_ST_HPD_PULSE]  = hot_plug_pulse_seen;
    assign status_set[`ARX_ST_TIMEOUT]    = timeout_rise;
    assign status_set[`ARX_ST_REPLY]      = AUX_REPLY_DONE_I;
    assign status_set[`ARX_ST_HPD_CHANGE] = hot_plug_change;
    assign status_set[`ARX_ST_HOT_PLUG_IRQ_PULSE]    = hot_plug_irq_pulse;

    // Write is illegal but treated as a clear, same as a read
    assign status_clear = sel_stat & (REG_RD_I | REG_WR_I);

    // Clear first, then set, so an event in the clearing cycle survives
    always @* begin
        status_d = status_q;
        if (status_clear) begin
            status_d = `ARX_STATUS_RST;
        end
        // Mask does not touch latching
        status_d = status_d | status_set;
    end

    always @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            overflow_q     <= 1'b0;
            reply_code_q   <= 4'h0;
            reply_cnt_q    <= `ARX_COUNT_RST;
            status_q       <= `ARX_STATUS_RST;
            mask_q         <= `ARX_MASK_RST;
            timeout_last_q <= 1'b0;
            IRQ_O          <= 1'b0;
        end else begin
            timeout_last_q <= AUX_REPLY_TIMEOUT_I;
            status_q       <= status_d;
            // Overflow: new event beats the read that clears it
            if (USER_FIFO_OVF_I) begin
                overflow_q <= 1'b1;
            end else if (REG_RD_I && sel_ovf) begin
                overflow_q <= 1'b0;
            end
            // Code only records; no retry is ever launched from here
            if (AUX_REPLY_DONE_I) begin
                reply_code_q <= AUX_REPLY_CODE_I;
            end
            if (REG_WR_I && sel_cnt) begin
                reply_cnt_q <= AUX_REPLY_DONE_I ? 8'h01
                                                : `ARX_COUNT_RST;
            end else if (AUX_REPLY_DONE_I) begin
                reply_cnt_q <= reply_cnt_q + 8'h01;
            end
            if (REG_WR_I && sel_mask) begin
                mask_q <= REG_WDATA_I[5:0];
            end
            // Registered, so the line follows status one cycle later
            IRQ_O <= |(status_q & ~mask_q);
        end
    end

    // Read data mux; unmapped addresses read zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (1'b1)
            sel_ovf: begin
                rdata_d[0] = overflow_q;
            end
            sel_raw: begin
                rdata_d[3:0] = raw_state;
            end
            sel_fifo: begin
                rdata_d[7:0] = fifo_head;
            end
            sel_code: begin
                rdata_d[3:0] = reply_code_q;
            end
            sel_cnt: begin
                rdata_d[7:0] = reply_cnt_q;
            end
            sel_stat: begin
                rdata_d[5:0] = status_q;
            end
            sel_mask: begin
                rdata_d[5:0] = mask_q;
            end
            sel_dur: begin
                rdata_d[15:0] = hot_plug_duration;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O  <= 32'h0000_0000;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
            if (REG_RD_I) begin
                REG_RDATA_O <= rdata_d;
            end
        end
    end

endmodule
`default_nettype wire

// file: arx_regs.vh
`ifndef ARX_REGS_VH
`define ARX_REGS_VH

// Register offsets on the host register port (byte addresses)
`define ARX_OFS_USER_OVF    12'h110
`define ARX_OFS_RAW_STATE   12'h130
`define ARX_OFS_REPLY_FIFO  12'h134
`define ARX_OFS_REPLY_CODE  12'h138
`define ARX_OFS_REPLY_CNT   12'h13C
`define ARX_OFS_IRQ_STATUS  12'h140
`define ARX_OFS_IRQ_MASK    12'h144
`define ARX_OFS_HPD_DUR     12'h150

// Interrupt status and mask bit positions
`define ARX_ST_EXT_PKT      5
`define ARX_ST_HPD_PULSE    4
`define ARX_ST_TIMEOUT      3
`define ARX_ST_REPLY        2
`define ARX_ST_HPD_CHANGE   1
`define ARX_ST_HOT_PLUG_IRQ_PULSE      0

// Raw state bit positions
`define ARX_RAW_TIMEOUT     3
`define ARX_RAW_REPLY       2
`define ARX_RAW_REQUEST     1
`define ARX_RAW_HPD         0

// Reset values
`define ARX_MASK_RST        6'h3F
`define ARX_STATUS_RST      6'h00
`define ARX_COUNT_RST       8'h00

// Timing
`define ARX_CLK_NS          4
`define ARX_US_NS           1000
`define ARX_US_CYC          (`ARX_US_NS / `ARX_CLK_NS)
`define ARX_HPD_LOSS_US     2000
`define ARX_HPD_LOSS_CYC    (`ARX_HPD_LOSS_US * `ARX_US_CYC)
`define ARX_IRQ_MIN_US      500
`define ARX_IRQ_MAX_US      1000

// Reply FIFO
`define ARX_FIFO_DEPTH      16

`endif

// file: arx_reply_fifo.v
`timescale 1ns/1ns
`default_nettype none
`include "arx_regs.vh"

module arx_reply_fifo (
    input  wire         clk_i,
    input  wire         rst_n_i,
    // Control
    input  wire         flush_i,
    input  wire         push_i,
    input  wire [7:0]   push_data_i,
    input  wire         pop_i,
    // State
    output wire [7:0]   head_o,
    output wire [4:0]   count_o
);
    reg  [7:0] mem_q [0:`ARX_FIFO_DEPTH-1];
    reg  [3:0] wr_ptr_q;
    reg  [3:0] rd_ptr_q;
    reg  [4:0] count_q;
    wire       empty;
    wire       full;
    wire       do_push;
    wire       do_pop;

    assign empty   = (count_q == 5'h00);
    assign full    = (count_q == 5'h10);
    assign do_push = push_i & ~full;
    assign do_pop  = pop_i & ~empty;
    // Empty FIFO reads as zero
    assign head_o  = empty ? 8'h00 : mem_q[rd_ptr_q];
    assign count_o = count_q;

    always @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i || flush_i) begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            count_q  <= 5'h00;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 4'h1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 5'h01;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: arx_hpd_mon.v
`timescale 1ns/1ns
`default_nettype none
`include "arx_regs.vh"

module arx_hpd_mon #(
    parameter LOSS_CYC = `ARX_HPD_LOSS_CYC
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire         hot_plug_level_i,
    // One-cycle events
    output reg          hot_plug_change_o,
    output reg          hot_plug_pulse_seen_o,
    output reg          hot_plug_irq_pulse_o,
    // Last pulse width in microseconds
    output reg  [15:0]  duration_o
);
    localparam [31:0] US_LAST_W = `ARX_US_CYC - 1;
    localparam [31:0] IRQ_MIN_W = `ARX_IRQ_MIN_US;
    localparam [31:0] IRQ_MAX_W = `ARX_IRQ_MAX_US;
    localparam [7:0]  US_LAST   = US_LAST_W[7:0];
    localparam [31:0] LOSS_LAST = LOSS_CYC - 1;
    localparam [15:0] IRQ_MIN   = IRQ_MIN_W[15:0];
    localparam [15:0] IRQ_MAX   = IRQ_MAX_W[15:0];

    reg         level_q;
    reg         present_q;
    reg  [31:0] low_cyc_q;
    reg  [7:0]  sub_q;
    reg  [15:0] us_q;
    wire        rise;

    assign rise = hot_plug_level_i & ~level_q;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_q               <= 1'b0;
            present_q             <= 1'b0;
            low_cyc_q             <= 32'h0000_0000;
            sub_q                 <= 8'h00;
            us_q                  <= 16'h0000;
            hot_plug_change_o     <= 1'b0;
            hot_plug_pulse_seen_o <= 1'b0;
            hot_plug_irq_pulse_o  <= 1'b0;
            duration_o            <= 16'h0000;
        end else begin
            level_q               <= hot_plug_level_i;
            hot_plug_change_o     <= 1'b0;
            hot_plug_pulse_seen_o <= 1'b0;
            hot_plug_irq_pulse_o  <= 1'b0;
            if (hot_plug_level_i) begin
                low_cyc_q <= 32'h0000_0000;
                sub_q     <= 8'h00;
                us_q      <= 16'h0000;
            end else begin
                // Width counters low_cyc_q and us_q saturate rather than wrap; sub_q wraps each microsecond
                if (low_cyc_q != LOSS_LAST) begin
                    low_cyc_q <= low_cyc_q + 32'h0000_0001;
                end
                if (sub_q == US_LAST) begin
                    sub_q <= 8'h00;
                    if (us_q != 16'hFFFF) begin
                        us_q <= us_q + 16'h0001;
                    end
                end else begin
                    sub_q <= sub_q + 8'h01;
                end
            end
            if (rise && !present_q) begin
                // Presence is reported at once
                present_q         <= 1'b1;
                hot_plug_change_o <= 1'b1;
            end else if (rise) begin
                hot_plug_pulse_seen_o <= 1'b1;
                duration_o            <= us_q;
                if (us_q >= IRQ_MIN && us_q <= IRQ_MAX) begin
                    hot_plug_irq_pulse_o <= 1'b1;
                end
            end else if (!hot_plug_level_i && present_q &&
                         low_cyc_q == LOSS_LAST) begin
                // Low for the full loss time counts as unplug
                present_q         <= 1'b0;
                hot_plug_change_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: arx_aux_reply_irq_status_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module arx_aux_reply_irq_status_assertions #(
    parameter HPD_LOSS_CYC = 500000
) (
    // Clock, reset and register port
    input wire logic        CORE_CLK_I,
    input wire logic        RST_N_I,
    input wire logic [11:0] REG_ADDR_I,
    input wire logic        REG_WR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic        REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic        REG_RVALID_O,
    // Event sources and interrupt
    input wire logic        AUX_REQ_ACTIVE_I,
    input wire logic        AUX_REPLY_ACTIVE_I,
    input wire logic        AUX_REPLY_DONE_I,
    input wire logic [3:0]  AUX_REPLY_CODE_I,
    input wire logic        AUX_REPLY_TIMEOUT_I,
    input wire logic        USER_FIFO_OVF_I,
    input wire logic        EXTENDED_PACKET_SENT_I,
    input wire logic        HOT_PLUG_I,
    input wire logic        IRQ_O
);
default clocking cb @(posedge CORE_CLK_I); endclocking
default disable iff (!RST_N_I);
reg  [5:0] mask_q;
reg  [3:0] code_q;
reg  [7:0] cnt_q;
reg  [2:0] hp_cnt_q;
wire       wr_cnt = REG_WR_I && REG_ADDR_I == 12'h13C;
wire       rd_st  = REG_RD_I && REG_ADDR_I == 12'h140;
wire       wr_st  = REG_WR_I && REG_ADDR_I == 12'h140;
wire       rd_ovf = REG_RD_I && REG_ADDR_I == 12'h110;
always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
        mask_q   <= 6'h3F;
        code_q   <= 4'h0;
        cnt_q    <= 8'h00;
        hp_cnt_q <= 3'h0;
    end else begin
        if (REG_WR_I && REG_ADDR_I == 12'h144) begin
            mask_q <= REG_WDATA_I[5:0];
        end
        if (AUX_REPLY_DONE_I) begin
            code_q <= AUX_REPLY_CODE_I;
            cnt_q  <= wr_cnt ? 8'h01 : cnt_q + 8'h01;
        end else if (wr_cnt) begin
            cnt_q <= 8'h00;
        end
        if (!HOT_PLUG_I) begin
            hp_cnt_q <= 3'h0;
        end else if (hp_cnt_q != 3'h7) begin
            hp_cnt_q <= hp_cnt_q + 3'h1;
        end
    end
end
// Hot-plug must be settled so that no late pulse event sneaks in
sequence quiet_s;
    !AUX_REPLY_DONE_I && !EXTENDED_PACKET_SENT_I && hp_cnt_q >= 3'h4
    && !$rose(AUX_REPLY_TIMEOUT_I);
endsequence
stat_rd_clr_a: assert property (
    rd_st ##0 quiet_s ##1 quiet_s |=> !IRQ_O
) else $error("status read left irq high");
stat_wr_clr_a: assert property (
    wr_st ##0 quiet_s ##1 quiet_s |=> !IRQ_O
) else $error("status write left irq high");
rvalid_pulse_a: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read got no valid");
rvalid_cause_a: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("valid without read");
raw_live_a: assert property (
    REG_RD_I && REG_ADDR_I == 12'h130 |=> REG_RDATA_O[31:1] ==
    {28'h000_0000, $past(AUX_REPLY_TIMEOUT_I), $past(AUX_REPLY_ACTIVE_I),
    $past(AUX_REQ_ACTIVE_I)}
) else $error("raw state mismatch");
code_val_a: assert property (
    REG_RD_I && REG_ADDR_I == 12'h138
    |=> REG_RDATA_O == {28'h000_0000, $past(code_q)}
) else $error("reply code mismatch");
cnt_val_a: assert property (
    REG_RD_I && REG_ADDR_I == 12'h13C
    |=> REG_RDATA_O == {24'h00_0000, $past(cnt_q)}
) else $error("reply count mismatch");
ovf_set_a: assert property (
    USER_FIFO_OVF_I ##1 !rd_ovf ##1 rd_ovf |=> REG_RDATA_O[0]
) else $error("overflow not flagged");
ovf_clr_a: assert property (
    (rd_ovf && !USER_FIFO_OVF_I) ##1 !USER_FIFO_OVF_I ##1 rd_ovf
    |=> REG_RDATA_O == 32'h0000_0000
) else $error("overflow not cleared by read");
irq_unmask_a: assert property (
    (AUX_REPLY_DONE_I && !mask_q[2] && !REG_WR_I) ##1 !REG_WR_I |=> IRQ_O
) else $error("unmasked reply gave no irq");
irq_masked_a: assert property (mask_q == 6'h3F |=> !IRQ_O)
    else $error("irq with all masked");
cover property (rd_st ##0 quiet_s);
cover property (AUX_REPLY_DONE_I && !mask_q[2]);
cover property (USER_FIFO_OVF_I ##1 !rd_ovf ##1 rd_ovf);
endmodule
bind arx_aux_reply_irq_status arx_aux_reply_irq_status_assertions #(
    .HPD_LOSS_CYC(HPD_LOSS_CYC)
) chk_u (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
    .AUX_REQ_ACTIVE_I(AUX_REQ_ACTIVE_I),
    .AUX_REPLY_ACTIVE_I(AUX_REPLY_ACTIVE_I),
    .AUX_REPLY_DONE_I(AUX_REPLY_DONE_I),
    .AUX_REPLY_CODE_I(AUX_REPLY_CODE_I),
    .AUX_REPLY_TIMEOUT_I(AUX_REPLY_TIMEOUT_I),
    .USER_FIFO_OVF_I(USER_FIFO_OVF_I),
    .EXTENDED_PACKET_SENT_I(EXTENDED_PACKET_SENT_I),
    .HOT_PLUG_I(HOT_PLUG_I), .IRQ_O(IRQ_O)
);
`default_nettype wire

// file: arx_sink_model.sv
`timescale 1ns/1ns
`default_nettype none
module arx_sink_model (
    input  wire logic       clk_i,
    // Hot-plug line and reply detector view
    output var  logic       hot_plug_o,
    output var  logic       reply_active_o,
    output var  logic       byte_vld_o,
    output var  logic [7:0] byte_o,
    output var  logic       done_o,
    output var  logic [3:0] code_o,
    output var  logic       timeout_o
);
initial begin
    hot_plug_o     = 1'b0;
    reply_active_o = 1'b0;
    byte_vld_o     = 1'b0;
    byte_o         = 8'h00;
    done_o         = 1'b0;
    code_o         = 4'h0;
    timeout_o      = 1'b0;
end
task automatic levels(input logic hp, input logic tmo, input logic ract);
    @(posedge clk_i);
    hot_plug_o     <= hp;
    timeout_o      <= tmo;
    reply_active_o <= ract;
endtask
// Idle data and code lines show the inverse of the last value
task automatic send_reply(input logic [7:0] b0, input int n,
                          input logic [3:0] code);
    int i;
    @(posedge clk_i);
    reply_active_o <= 1'b1;
    for (i = 0; i < n; i++) begin
        @(posedge clk_i);
        byte_vld_o <= 1'b1;
        byte_o     <= b0 + i[7:0];
    end
    @(posedge clk_i);
    byte_vld_o <= 1'b0;
    byte_o     <= ~byte_o;
    done_o     <= 1'b1;
    code_o     <= code;
    @(posedge clk_i);
    done_o         <= 1'b0;
    code_o         <= ~code;
    reply_active_o <= 1'b0;
endtask
endmodule
`default_nettype wire

// file: arx_aux_reply_irq_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module arx_aux_reply_irq_status_tb;
localparam int LOSS = 2000;
logic        clk = 1'b0;
logic        rst_n = 1'b0;
logic [11:0] reg_addr = 12'h000;
logic        reg_wr = 1'b0;
logic        reg_rd = 1'b0;
logic [31:0] reg_wdata = 32'h0000_0000;
logic        start = 1'b0;
logic [3:0]  len = 4'h0;
logic        req_act = 1'b0;
logic        ovf = 1'b0;
logic        ext = 1'b0;
wire  [31:0] rdata;
wire         rvalid, irq, hp, ract, bvld, done, tmo;
wire  [7:0]  rbyte;
wire  [3:0]  code;
int          num_errors = 0;
int          tests_run = 0;
always #2 clk = ~clk;
arx_sink_model sink_u (.clk_i(clk), .hot_plug_o(hp), .reply_active_o(ract),
    .byte_vld_o(bvld), .byte_o(rbyte), .done_o(done), .code_o(code),
    .timeout_o(tmo));
arx_aux_reply_irq_status #(.HPD_LOSS_CYC(LOSS)) dut_u (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(reg_addr),
    .REG_WR_I(reg_wr), .REG_WDATA_I(reg_wdata), .REG_RD_I(reg_rd),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .AUX_REQ_START_I(start),
    .AUX_REQ_LEN_I(len), .AUX_REQ_ACTIVE_I(req_act),
    .AUX_REPLY_ACTIVE_I(ract), .AUX_REPLY_BYTE_VLD_I(bvld),
    .AUX_REPLY_BYTE_I(rbyte), .AUX_REPLY_DONE_I(done),
    .AUX_REPLY_CODE_I(code), .AUX_REPLY_TIMEOUT_I(tmo),
    .USER_FIFO_OVF_I(ovf), .EXTENDED_PACKET_SENT_I(ext), .HOT_PLUG_I(hp),
    .IRQ_O(irq));
task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] seen,
                   input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
        num_errors++;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp,
                      input string nm);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", {31'h0000_0000, rvalid}, 32'h0000_0001);
    chk(nm, rdata, exp);
endtask
task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
endtask
task automatic do_reply(input logic [3:0] l, input int n,
                        input logic [7:0] b0, input logic [3:0] c);
    @(posedge clk);
    start <= 1'b1;
    len   <= l;
    @(posedge clk);
    start <= 1'b0;
    sink_u.send_reply(b0, n, c);
    // Leaves room for zero padding up to the requested length
    repeat (20) @(posedge clk);
endtask
task automatic pulse_ext;
    @(posedge clk);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
endtask
task automatic t_reset;
    rd_reg(12'h144, 32'h0000_003F, "mask");
    rd_reg(12'h140, 32'h0000_0000, "status");
    rd_reg(12'h13C, 32'h0000_0000, "count");
    rd_reg(12'h200, 32'h0000_0000, "unmapped");
    rd_reg(12'h134, 32'h0000_0000, "fifo empty");
    $display("reset test done");
endtask
task automatic t_hpd;
    sink_u.levels(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    rd_reg(12'h140, 32'h0000_0002, "hpd up");
    sink_u.levels(1'b0, 1'b0, 1'b0);
    // Short pulse stays below the IRQ pulse window, so bit 0 stays clear
    repeat (509) @(posedge clk);
    sink_u.levels(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    rd_reg(12'h140, 32'h0000_0010, "pulse");
    rd_reg(12'h150, 32'h0000_0002, "duration");
    sink_u.levels(1'b0, 1'b0, 1'b0);
    repeat (LOSS + 50) @(posedge clk);
    rd_reg(12'h140, 32'h0000_0002, "hpd loss");
    sink_u.levels(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    rd_reg(12'h140, 32'h0000_0002, "hpd back");
    $display("hot-plug test done");
endtask
task automatic t_reply;
    do_reply(4'h1, 2, 8'hA5, 4'h6);
    rd_reg(12'h138, 32'h0000_0006, "code");
    rd_reg(12'h13C, 32'h0000_0001, "count");
    rd_reg(12'h134, 32'h0000_00A5, "byte0");
    rd_reg(12'h134, 32'h0000_00A6, "byte1");
    rd_reg(12'h134, 32'h0000_0000, "empty");
    rd_reg(12'h140, 32'h0000_0004, "reply st");
    do_reply(4'h0, 2, 8'h20, 4'h9);
    rd_reg(12'h138, 32'h0000_0009, "code");
    rd_reg(12'h134, 32'h0000_0020, "byte0");
    rd_reg(12'h134, 32'h0000_0000, "excess");
    do_reply(4'h1, 2, 8'h30, 4'h0);
    rd_reg(12'h134, 32'h0000_0030, "byte0");
    do_reply(4'h0, 1, 8'h40, 4'h0);
    rd_reg(12'h134, 32'h0000_0040, "flushed");
    rd_reg(12'h13C, 32'h0000_0004, "count");
    wr_reg(12'h13C, 32'hFFFF_FFFF);
    rd_reg(12'h13C, 32'h0000_0000, "count clr");
    // Short reply: one byte, then zero padding up to three
    do_reply(4'h2, 1, 8'h60, 4'h0);
    rd_reg(12'h134, 32'h0000_0060, "short0");
    rd_reg(12'h134, 32'h0000_0000, "pad1");
    rd_reg(12'h134, 32'h0000_0000, "pad2");
    rd_reg(12'h13C, 32'h0000_0001, "count again");
    rd_reg(12'h140, 32'h0000_0004, "reply st");
    $display("reply test done");
endtask
task automatic t_irq;
    wr_reg(12'h144, 32'h0000_001F);
    pulse_ext();
    chk("irq on", {31'h0000_0000, irq}, 32'h0000_0001);
    rd_reg(12'h140, 32'h0000_0020, "ext st");
    repeat (2) @(posedge clk);
    #1;
    chk("irq off", {31'h0000_0000, irq}, 32'h0000_0000);
    wr_reg(12'h144, 32'h0000_003F);
    pulse_ext();
    chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
    rd_reg(12'h140, 32'h0000_0020, "masked st");
    wr_reg(12'h144, 32'h0000_0000);
    do_reply(4'h0, 1, 8'h55, 4'h0);
    #1;
    chk("irq reply", {31'h0000_0000, irq}, 32'h0000_0001);
    wr_reg(12'h140, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    chk("irq wr clr", {31'h0000_0000, irq}, 32'h0000_0000);
    rd_reg(12'h140, 32'h0000_0000, "wr clr st");
    wr_reg(12'h144, 32'h0000_003F);
    $display("interrupt test done");
endtask
task automatic t_ovf_raw;
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    rd_reg(12'h110, 32'h0000_0001, "ovf set");
    rd_reg(12'h110, 32'h0000_0000, "ovf clr");
    @(posedge clk);
    req_act <= 1'b1;
    sink_u.levels(1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    rd_reg(12'h130, 32'h0000_000F, "raw all");
    rd_reg(12'h140, 32'h0000_0008, "timeout st");
    @(posedge clk);
    req_act <= 1'b0;
    sink_u.levels(1'b1, 1'b0, 1'b0);
    rd_reg(12'h130, 32'h0000_0001, "raw hpd");
    $display("overflow and raw test done");
endtask
initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report();
end
initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_hpd();
    t_reply();
    t_irq();
    t_ovf_raw();
    final_report();
end
endmodule
`default_nettype wire
